// ==== include/dsf_pkg.sv ====
// constants for the dual-channel serial output framer
// assumes one 40 MHz system clock; converter and direct pins arrive unsynchronised
// Function
// [R1] capture sample on sample clock rising edge
// [R2] host pulses relock high for one microsecond
// [R3] lock regained within several microseconds after relock
// [R4] four-level pin selects format and stabilizer
// [R5] per-channel power-down input, high reduces power
// [R6] serial port enable freezes all direct pins; here the relock pin still acts
// [R7] test input sends fixed pattern, msb first
// [R8] host drives alignment low in single-lane mode
// [R9] dual-lane: alignment low offsets half word
// [R10] lane count low dual, high lane one
// [R11] one bit per bit clock edge
// [R12] bit clock and frame low in power-down
// [R13] frame toggles exactly at word boundaries
// [R14] lane one words start at frame rise
// [R15] dual-lane: lane zero words start at fall
// [R16] dual alternates lanes, single uses lane one
// [R17] single-lane: lane zero held high impedance
// [R18] fourteen-bit word msb first per frame
package dsf_pkg;

  // system clock period
  localparam int unsigned CLK_PERIOD_NS   = 25;
  // worst-case relock time of the timing loop
  localparam int unsigned LOCK_TIME_NS    = 5000;
  // cycles until lock, rounded down
  localparam int unsigned LOCK_CYCLES_INT = LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  LOCK_CYCLES     = 8'(LOCK_CYCLES_INT);

  // sample word layout
  localparam int unsigned WORD_W    = 14;
  localparam logic [13:0] TEST_WORD = 14'h298e;
  // bit positions inside a word
  localparam logic [3:0]  BIT_FIRST = 4'h0;
  localparam logic [3:0]  HALF_WORD = 4'h7;
  localparam logic [3:0]  BIT_LAST  = 4'hd;

  // format pin levels as delivered by the level slicer
  localparam logic [1:0]  LVL_GND        = 2'h0;
  localparam logic [1:0]  LVL_THIRD      = 2'h1;
  localparam logic [1:0]  LVL_TWO_THIRDS = 2'h2;
  localparam logic [1:0]  LVL_SUPPLY     = 2'h3;

  // register port
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CFG    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [3:0]  CFG_DIV_RST = 4'h3;

  // status field positions
  localparam int unsigned ST_LOCKED = 0;
  localparam int unsigned ST_SINGLE = 1;
  localparam int unsigned ST_ALIGN  = 2;
  localparam int unsigned ST_TEST   = 3;
  localparam int unsigned ST_PD_A   = 4;
  localparam int unsigned ST_PD_B   = 5;
  localparam int unsigned ST_FMT    = 6;

endpackage

// ==== hw/dsf_framer.sv ====
// serial output framer and direct pin control of a dual converter
// assumes converter words stable around each sample clock rising edge
// and a bit clock much slower than the 40 MHz system clock
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module dsf_framer (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // converter side, asynchronous
  input  wire logic        i_sample_clock,
  input  wire logic [13:0] i_conv_word_a,
  input  wire logic [13:0] i_conv_word_b,
  // direct control pins, asynchronous
  input  wire logic [1:0]  i_format_and_stabilizer_select,
  input  wire logic        i_powerdown_channel_a,
  input  wire logic        i_powerdown_channel_b,
  input  wire logic        i_test_mode,
  input  wire logic        i_word_alignment_select,
  input  wire logic        i_lane_count_select,
  input  wire logic        i_serial_port_enable,
  input  wire logic        i_dll_relock,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  output logic      [31:0] o_rdata,
  // serial link
  output logic             o_serial_bit_clock,
  output logic             o_frame,
  output logic             o_lane_one_channel_a,
  output logic             o_lane_one_channel_b,
  output logic             o_lane_zero_channel_a,
  output logic             o_lane_zero_channel_b,
  output logic             o_lane_zero_oe_n,
  // core control
  output logic             o_duty_stabilize_en,
  output logic             o_powerdown_a,
  output logic             o_powerdown_b,
  output logic             o_dll_locked
);

  // complete module state
  typedef struct packed {
    logic        smp1;       // sample clock sync
    logic        smp2;
    logic        smp_prev;   // edge detector
    logic [13:0] cva1;       // channel a word sync
    logic [13:0] cva2;
    logic [13:0] cvb1;       // channel b word sync
    logic [13:0] cvb2;
    logic [1:0]  fmt1;       // pin syncs
    logic [1:0]  fmt2;
    logic        pda1;
    logic        pda2;
    logic        pdb1;
    logic        pdb2;
    logic        tst1;
    logic        tst2;
    logic        wam1;
    logic        wam2;
    logic        dlc1;
    logic        dlc2;
    logic        spi1;
    logic        spi2;
    logic        rel1;
    logic        rel2;
    logic        rel_prev;   // relock edge detector
    logic [1:0]  fmt;        // effective settings
    logic        pd_a;
    logic        pd_b;
    logic        test;
    logic        word_alignment_select;
    logic        lane_count_select;
    logic [7:0]  lock_cnt;   // relock countdown
    logic        locked;
    logic [3:0]  cfg_div;    // half-bit divider setting
    logic [3:0]  div_cnt;
    logic [3:0]  bit_idx;    // bit within current word
    logic        odd;        // next sample goes to lane zero
    logic [13:0] pend1_a;    // words waiting for their slot
    logic [13:0] pend0_a;
    logic [13:0] pend1_b;
    logic [13:0] pend0_b;
    logic [13:0] sh1_a;      // shift registers
    logic [13:0] sh0_a;
    logic [13:0] sh1_b;
    logic [13:0] sh0_b;
    logic        bclk;       // output flops
    logic        frame;
    logic        l1a;
    logic        l0a;
    logic        l1b;
    logic        l0b;
    logic        l0_oe_n;
    logic        stab;
    logic        pdo_a;
    logic        pdo_b;
    logic [31:0] rdata;
  } dsf_state_s;

  dsf_state_s  q;            // registered state
  dsf_state_s  d;            // next state
  logic [1:0]  rst_sync_q;   // reset release synchroniser
  logic        rst_n;        // synchronised reset
  logic        smp_edge;     // sample clock rising edge
  logic        run;          // link running
  logic        tick;         // half-bit enable
  logic [3:0]  idx_n;        // next bit index
  logic [3:0]  l0_start;     // lane zero word start
  logic [13:0] wa_fmt;       // formatted channel a word
  logic [13:0] wb_fmt;       // formatted channel b word

  // format pin: 2's complement at supply and two-thirds
  function automatic logic fmt_twos(input logic [1:0] lvl);
    fmt_twos = (lvl == dsf_pkg::LVL_SUPPLY) ||
               (lvl == dsf_pkg::LVL_TWO_THIRDS);
  endfunction

  // format pin: stabilizer at the two middle levels
  function automatic logic fmt_stab(input logic [1:0] lvl);
    fmt_stab = (lvl == dsf_pkg::LVL_THIRD) ||
               (lvl == dsf_pkg::LVL_TWO_THIRDS);
  endfunction

  // word for the link: test pattern or formatted conversion
  function automatic logic [13:0] word_out(input logic [13:0] raw,
                                           input logic [1:0]  lvl,
                                           input logic        tst);
    if (tst) begin
      word_out = dsf_pkg::TEST_WORD; // R7
    end else if (fmt_twos(lvl)) begin
      word_out = {~raw[13], raw[12:0]}; // R4
    end else begin
      word_out = raw;
    end
  endfunction

  // one lane step: load msb of pending word or shift, msb first
  function automatic logic [14:0] lane_step(input logic [13:0] sh,
                                            input logic [13:0] pend,
                                            input logic        load);
    if (load) begin
      lane_step = {pend, 1'b0}; // R18
    end else begin
      lane_step = {sh, 1'b0};
    end
  endfunction

  // reset is released through two flops
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // helper terms shared by next-state logic and checks
  assign smp_edge = q.smp2 && !q.smp_prev;
  assign run      = q.locked && !(q.pd_a && q.pd_b);
  assign tick     = run && (q.div_cnt >= q.cfg_div);
  assign idx_n    = (q.bit_idx == dsf_pkg::BIT_LAST) ?
                    dsf_pkg::BIT_FIRST : q.bit_idx + 4'h1;
  // lane zero starts mid-word unless aligned
  assign l0_start = q.word_alignment_select ? dsf_pkg::BIT_FIRST : dsf_pkg::HALF_WORD; // R9 R15
  assign wa_fmt   = word_out(q.cva2, q.fmt, q.test);
  assign wb_fmt   = word_out(q.cvb2, q.fmt, q.test);

  // next-state logic
  always_comb begin
    d = q;
    // two-flop synchronisers on every converter and direct pin
    d.smp1     = i_sample_clock;
    d.smp2     = q.smp1;
    d.smp_prev = q.smp2;
    d.cva1     = i_conv_word_a;
    d.cva2     = q.cva1;
    d.cvb1     = i_conv_word_b;
    d.cvb2     = q.cvb1;
    d.fmt1     = i_format_and_stabilizer_select;
    d.fmt2     = q.fmt1;
    d.pda1     = i_powerdown_channel_a;
    d.pda2     = q.pda1;
    d.pdb1     = i_powerdown_channel_b;
    d.pdb2     = q.pdb1;
    d.tst1     = i_test_mode;
    d.tst2     = q.tst1;
    d.wam1     = i_word_alignment_select;
    d.wam2     = q.wam1;
    d.dlc1     = i_lane_count_select;
    d.dlc2     = q.dlc1;
    d.spi1     = i_serial_port_enable;
    d.spi2     = q.spi1;
    d.rel1     = i_dll_relock;
    d.rel2     = q.rel1;
    d.rel_prev = q.rel2;

    // direct pins other than relock take effect only with the serial port off
    if (!q.spi2) begin // R6
      d.fmt  = q.fmt2;
      d.pd_a = q.pda2;
      d.pd_b = q.pdb2;
      d.test = q.tst2;
      d.lane_count_select  = q.dlc2;
      // alignment is ignored in single-lane mode
      d.word_alignment_select  = q.wam2 && !q.dlc2; // R8
    end

    // relock: restart the lock countdown on the pulse rise
    if (q.rel2 && !q.rel_prev) begin // R3
      d.lock_cnt = dsf_pkg::LOCK_CYCLES;
      d.locked   = 1'b0;
    end else if (q.lock_cnt != 8'h00) begin
      d.lock_cnt = q.lock_cnt - 8'h01;
    end else begin
      d.locked   = 1'b1;
    end

    // capture a new sample on each sample clock rise
    if (smp_edge) begin // R1
      if (q.lane_count_select || !q.odd) begin // R10 R16
        d.pend1_a = wa_fmt;
        d.pend1_b = wb_fmt;
      end else begin
        d.pend0_a = wa_fmt;
        d.pend0_b = wb_fmt;
      end
      // alternate lanes only in dual-lane mode
      d.odd = q.lane_count_select ? 1'b0 : ~q.odd; // R16
    end

    // half-bit divider and word sequencer
    if (!run) begin
      // both channels powered down or relocking: clock and frame low
      d.div_cnt = 4'h0;
      d.bit_idx = dsf_pkg::BIT_LAST;
      d.bclk    = 1'b0; // R12
      d.frame   = 1'b0; // R12
    end else if (tick) begin
      d.div_cnt = 4'h0;
      d.bit_idx = idx_n;
      // one bit per edge; clock high on even bits
      d.bclk    = ~idx_n[0]; // R11
      // frame high for the first half of the word
      d.frame   = idx_n < dsf_pkg::HALF_WORD; // R13 R14 R15
      // channel a lanes hold last state while powered down
      if (!q.pd_a) begin
        {d.l1a, d.sh1_a} = lane_step(q.sh1_a, q.pend1_a,
                                     idx_n == dsf_pkg::BIT_FIRST); // R14
        if (!q.lane_count_select) begin
          {d.l0a, d.sh0_a} = lane_step(q.sh0_a, q.pend0_a,
                                       idx_n == l0_start); // R9 R15
        end
      end
      // channel b lanes likewise
      if (!q.pd_b) begin
        {d.l1b, d.sh1_b} = lane_step(q.sh1_b, q.pend1_b,
                                     idx_n == dsf_pkg::BIT_FIRST); // R14
        if (!q.lane_count_select) begin
          {d.l0b, d.sh0_b} = lane_step(q.sh0_b, q.pend0_b,
                                       idx_n == l0_start); // R9 R15
        end
      end
    end else begin
      d.div_cnt = q.div_cnt + 4'h1;
    end

    // lane zero released in single-lane mode
    d.l0_oe_n = q.lane_count_select; // R17
    // core controls
    d.stab  = fmt_stab(q.fmt); // R4
    d.pdo_a = q.pd_a; // R5
    d.pdo_b = q.pd_b; // R5

    // register writes
    if (i_wr_en) begin
      if (i_addr == dsf_pkg::ADDR_CFG) begin
        d.cfg_div = i_wdata[3:0];
      end
    end

    // register reads, data valid one cycle later only
    d.rdata = 32'h0000_0000;
    if (i_rd_en) begin
      if (i_addr == dsf_pkg::ADDR_CFG) begin
        d.rdata[3:0] = q.cfg_div;
      end else if (i_addr == dsf_pkg::ADDR_STATUS) begin
        d.rdata[dsf_pkg::ST_LOCKED]       = q.locked;
        d.rdata[dsf_pkg::ST_SINGLE]       = q.lane_count_select;
        d.rdata[dsf_pkg::ST_ALIGN]        = q.word_alignment_select;
        d.rdata[dsf_pkg::ST_TEST]         = q.test;
        d.rdata[dsf_pkg::ST_PD_A]         = q.pd_a;
        d.rdata[dsf_pkg::ST_PD_B]         = q.pd_b;
        d.rdata[dsf_pkg::ST_FMT+1 -: 2]   = q.fmt;
      end
    end
  end

  // state register
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.cfg_div  <= dsf_pkg::CFG_DIV_RST;
      q.lock_cnt <= dsf_pkg::LOCK_CYCLES;
      q.bit_idx  <= dsf_pkg::BIT_LAST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign o_rdata               = q.rdata;
  assign o_serial_bit_clock    = q.bclk;
  assign o_frame               = q.frame;
  assign o_lane_one_channel_a  = q.l1a;
  assign o_lane_one_channel_b  = q.l1b;
  assign o_lane_zero_channel_a = q.l0a;
  assign o_lane_zero_channel_b = q.l0b;
  assign o_lane_zero_oe_n      = q.l0_oe_n;
  assign o_duty_stabilize_en   = q.stab;
  assign o_powerdown_a         = q.pdo_a;
  assign o_powerdown_b         = q.pdo_b;
  assign o_dll_locked          = q.locked;

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  // new formatted sample lands in lane one slot
  property p_capture;
    (smp_edge && q.lane_count_select) |=> (q.pend1_a == $past(wa_fmt));
  endproperty
  a_capture: assert property (p_capture) // R1
    else $error("sample not captured on sample clock edge");

  // relock: unlocked for a while, locked again within bound
  sequence s_relock_rise;
    q.rel2 && !q.rel_prev;
  endsequence
  sequence s_unlocked;
    !o_dll_locked [*8];
  endsequence
  property p_relock;
    s_relock_rise |=> s_unlocked ##[1:205] o_dll_locked;
  endproperty
  a_relock: assert property (p_relock) // R3
    else $error("relock timing wrong");

  // stabilizer follows the format level
  property p_stab;
    ##1 (o_duty_stabilize_en == fmt_stab($past(q.fmt)));
  endproperty
  a_stab: assert property (p_stab) // R4
    else $error("stabilizer decode wrong");

  // power-down pin reaches the core
  property p_pd;
    (q.pda2 && !q.spi2) |-> ##2 o_powerdown_a;
  endproperty
  a_pd: assert property (p_pd) // R5
    else $error("power-down not applied");

  // serial port enable freezes settings
  property p_spi;
    q.spi2 |=> ($stable(q.pd_a) && $stable(q.lane_count_select) && $stable(q.test)
                && $stable(q.fmt) && $stable(q.word_alignment_select));
  endproperty
  a_spi: assert property (p_spi) // R6
    else $error("direct pin acted with serial port on");

  // test pattern replaces data
  property p_test;
    (smp_edge && q.test && q.lane_count_select) |=> (q.pend1_a == dsf_pkg::TEST_WORD);
  endproperty
  a_test: assert property (p_test) // R7
    else $error("test pattern missing");

  // bit clock toggles on every half-bit tick
  property p_ddr;
    tick |=> (o_serial_bit_clock != $past(o_serial_bit_clock));
  endproperty
  a_ddr: assert property (p_ddr) // R11
    else $error("bit clock did not toggle");

  // both channels down: clock and frame low
  property p_pd_low;
    (q.pd_a && q.pd_b) |=> (!o_serial_bit_clock && !o_frame);
  endproperty
  a_pd_low: assert property (p_pd_low) // R12
    else $error("link clock active in power-down");

  // frame rises at a word start with its msb out
  property p_frame_rise;
    $rose(o_frame) |-> (q.bit_idx == dsf_pkg::BIT_FIRST);
  endproperty
  a_frame_rise: assert property (p_frame_rise) // R14
    else $error("frame rise off word boundary");

  // running frame falls at mid-word
  property p_frame_fall;
    ($fell(o_frame) && run) |-> (q.bit_idx == dsf_pkg::HALF_WORD);
  endproperty
  a_frame_fall: assert property (p_frame_fall) // R13
    else $error("frame fall off word boundary");

  // aligned dual lane: lane zero loads with lane one
  property p_align;
    (tick && !q.lane_count_select && q.word_alignment_select && !q.pd_a && idx_n == dsf_pkg::BIT_FIRST)
      |=> (o_lane_zero_channel_a == $past(q.pend0_a[13]));
  endproperty
  a_align: assert property (p_align) // R9
    else $error("aligned lane zero word not started");

  // single lane releases lane zero
  property p_single;
    q.lane_count_select |=> o_lane_zero_oe_n;
  endproperty
  a_single: assert property (p_single) // R17
    else $error("lane zero driven in single-lane mode");

endmodule

// ==== verification/dsf_rx_model.sv ====
// receiver model: deserializes the four lanes with bit clock and frame
// assumes design outputs are registered on the same system clock
`timescale 1ns/100ps
module dsf_rx_model (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // mode and serial link
  input  wire logic        i_align,
  input  wire logic        i_bclk,
  input  wire logic        i_frame,
  input  wire logic [3:0]  i_lanes,
  // received words, channel a in upper half
  output logic             o_v1,
  output logic             o_v0,
  output logic      [27:0] o_w1,
  output logic      [27:0] o_w0
);
  logic        bclk_q;   // last bit clock level
  logic        frame_q;  // last frame level
  logic [4:0]  n1;       // lane one bit index, 31 = lost
  logic [4:0]  n0;       // lane zero bit index
  logic [27:0] s1;       // lane one shifters
  logic [27:0] s0;       // lane zero shifters

  // one bit per bit clock edge, words framed by frame edges
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bclk_q  = 1'b0;
      frame_q = 1'b0;
      n1      = 5'h1f;
      n0      = 5'h1f;
      o_v1   <= 1'b0;
      o_v0   <= 1'b0;
    end else begin
      o_v1 <= 1'b0;
      o_v0 <= 1'b0;
      if (i_bclk !== bclk_q) begin
        // lane one restarts at frame rise only
        if (i_frame && !frame_q) n1 = 5'h0;
        // lane zero at fall, or at rise when aligned
        if (i_align ? (i_frame && !frame_q) : (!i_frame && frame_q))
          n0 = 5'h0;
        s1 = {s1[26:14], i_lanes[3], s1[12:0], i_lanes[2]};
        s0 = {s0[26:14], i_lanes[1], s0[12:0], i_lanes[0]};
        if (n1 == 5'hd) begin
          o_w1 <= s1;
          o_v1 <= 1'b1;
        end
        if (n0 == 5'hd) begin
          o_w0 <= s0;
          o_v0 <= 1'b1;
        end
        if (n1 != 5'h1f) n1 = n1 + 5'h1;
        if (n0 != 5'h1f) n0 = n0 + 5'h1;
      end
      bclk_q  = i_bclk;
      frame_q = i_frame;
    end
  end
endmodule

// ==== verification/dsf_framer_tb_top.sv ====
// self-checking bench for the serial output framer
// assumes the receiver model and the framer compile beforehand
`timescale 1ns/100ps
module dsf_framer_tb_top;
  localparam int MAX_CYC = 60000;  // ceiling on the run
  logic        clk, rst_n, smp_clk, wr_en, rd_en, rd_q;
  logic [13:0] wa, wb;
  logic [1:0]  fmt;
  logic        pd_a, pd_b, tst, align, single, spe, relock;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic        bclk, frame, l1a, l1b, l0a, l0b, oe_n, dcs, pwa, pwb, locked;
  logic        v1, v0;
  logic [27:0] w1, w0, e1, e0;
  logic [27:0] q1[$], q0[$];  // expected lane words
  logic [31:0] qr[$];         // expected read data
  int          miscompares, n_compared, cyc, seed, k;

  // system clock and free running sample clock of another phase
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    smp_clk = 1'b0;
    #37;
    forever #100 smp_clk = ~smp_clk;
  end

  dsf_framer u_dut (
    .i_clock(clk), .i_rst_n(rst_n), .i_sample_clock(smp_clk),
    .i_conv_word_a(wa), .i_conv_word_b(wb),
    .i_format_and_stabilizer_select(fmt),
    .i_powerdown_channel_a(pd_a), .i_powerdown_channel_b(pd_b),
    .i_test_mode(tst), .i_word_alignment_select(align),
    .i_lane_count_select(single), .i_serial_port_enable(spe),
    .i_dll_relock(relock), .i_addr(addr), .i_wdata(wdata),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rdata(rdata),
    .o_serial_bit_clock(bclk), .o_frame(frame),
    .o_lane_one_channel_a(l1a), .o_lane_one_channel_b(l1b),
    .o_lane_zero_channel_a(l0a), .o_lane_zero_channel_b(l0b),
    .o_lane_zero_oe_n(oe_n), .o_duty_stabilize_en(dcs),
    .o_powerdown_a(pwa), .o_powerdown_b(pwb), .o_dll_locked(locked));

  dsf_rx_model u_rx (
    .i_clock(clk), .i_rst_n(rst_n), .i_align(align), .i_bclk(bclk),
    .i_frame(frame), .i_lanes({l1a, l1b, l0a, l0b}),
    .o_v1(v1), .o_v0(v0), .o_w1(w1), .o_w0(w0));

  // compare tasks, one per kind of result
  task automatic chk_word(input logic [27:0] got, input logic [27:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t rdata %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // register port cycles
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    qr.push_back(exp);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
  endtask

  // converter format: two's complement flips the msb
  function automatic logic [13:0] fmtd(input logic [13:0] w,
                                       input logic [1:0] c);
    if (c == dsf_pkg::LVL_SUPPLY || c == dsf_pkg::LVL_TWO_THIRDS)
      return {~w[13], w[12:0]};
    return w;
  endfunction

  // flush three words, then expect two steady words on lane one, and on lane zero when dual
  task automatic phase(input logic [27:0] e, input logic dual);
    int n;
    n = 0;
    while (n < 3) begin
      @(posedge clk);
      if (v1) n++;
    end
    repeat (2) begin
      q1.push_back(e);
      if (dual) q0.push_back(e);
    end
    while (q1.size() != 0 || q0.size() != 0) @(posedge clk);
  endtask

  task automatic wait_lock();
    for (k = 0; k < 400 && locked !== 1'b1; k++) @(posedge clk);
    chk_flag(locked, 1'b1);
  endtask

  // watcher: compare results against the oldest note
  always @(posedge clk) begin
    rd_q <= rd_en;
    if (rd_q && qr.size() != 0) chk_data(rdata, qr.pop_front());
    if (v1 && q1.size() != 0) begin
      e1 = q1.pop_front();
      chk_word(w1, e1);
    end
    if (v0 && q0.size() != 0) begin
      e0 = q0.pop_front();
      chk_word(w0, e0);
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == MAX_CYC) begin
      miscompares++;
      $display("CHECK FAILED %0t timeout", $time);
      conclude();
    end
  end

  // main sequence
  initial begin
    seed = 44;
    rst_n = 1'b0;
    {wa, wb, fmt, pd_a, pd_b, tst, align, single, spe, relock} = '0;
    {addr, wdata, wr_en, rd_en} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wait_lock();
    reg_rd(dsf_pkg::ADDR_CFG, {28'h000_0000, dsf_pkg::CFG_DIV_RST});
    reg_rd(dsf_pkg::ADDR_STATUS, 32'h0000_0001);
    reg_rd(8'h08, 32'h0000_0000);
    reg_wr(dsf_pkg::ADDR_CFG, 32'h0000_0002);
    reg_rd(dsf_pkg::ADDR_CFG, 32'h0000_0002);
    // every format code, dual lane offset words
    for (int c = 0; c < 4; c++) begin
      fmt <= 2'(c);
      wa  <= 14'($random(seed));
      wb  <= 14'($random(seed));
      repeat (6) @(posedge clk);
      chk_flag(dcs, c == 1 || c == 2);
      phase({fmtd(wa, 2'(c)), fmtd(wb, 2'(c))}, 1'b1);
    end
    align <= 1'b1;
    phase({fmtd(wa, fmt), fmtd(wb, fmt)}, 1'b1);
    tst <= 1'b1;
    phase({dsf_pkg::TEST_WORD, dsf_pkg::TEST_WORD}, 1'b1);
    spe <= 1'b1;
    repeat (6) @(posedge clk);
    tst <= 1'b0;
    phase({dsf_pkg::TEST_WORD, dsf_pkg::TEST_WORD}, 1'b1);
    spe <= 1'b0;
    align <= 1'b0;
    single <= 1'b1;
    repeat (6) @(posedge clk);
    chk_flag(oe_n, 1'b1);
    reg_rd(dsf_pkg::ADDR_STATUS, 32'h0000_00c3);
    phase({fmtd(wa, fmt), fmtd(wb, fmt)}, 1'b0);
    single <= 1'b0;
    repeat (6) @(posedge clk);
    chk_flag(oe_n, 1'b0);
    pd_a <= 1'b1;
    repeat (6) @(posedge clk);
    chk_flag(pwa, 1'b1);
    chk_flag(pwb, 1'b0);
    pd_b <= 1'b1;
    repeat (8) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      chk_flag(bclk | frame, 1'b0);
    end
    pd_a <= 1'b0;
    pd_b <= 1'b0;
    phase({fmtd(wa, fmt), fmtd(wb, fmt)}, 1'b1);
    relock <= 1'b1;
    repeat (40) @(posedge clk);
    relock <= 1'b0;
    @(posedge clk);
    chk_flag(locked, 1'b0);
    wait_lock();
    phase({fmtd(wa, fmt), fmtd(wb, fmt)}, 1'b1);
    conclude();
  end
endmodule
